// File: rtl/scan_debug_defs.svh
`ifndef SCAN_DEBUG_DEFS_SVH
`define SCAN_DEBUG_DEFS_SVH

`define IR_WIDTH              4
`define IR_CAPTURE_VALUE      4'h1
`define INSTR_EXTEST          4'h0
`define INSTR_IDCODE          4'h1
`define INSTR_SAMPLE_PRELOAD  4'h2
`define INSTR_DEBUG_ACCESS_A  4'h8
`define INSTR_DEBUG_ACCESS_B  4'h9
`define INSTR_DEBUG_ACCESS_C  4'ha
`define INSTR_DEBUG_ACCESS_D  4'hb
`define INSTR_RESET_REQUEST   4'hc
`define INSTR_BYPASS          4'hf

`define ADDR_DEBUG_MESSAGE    6'h31
`define ADDR_CORE_CONTROL     6'h35
`define DEBUG_MESSAGE_RESET   8'h00
`define CORE_CONTROL_RESET    8'h00
`define DIRTY_BIT             7
`define INTERFACE_DISABLE_BIT 7
`define TIMED_WRITE_WINDOW    3'h4

`define ID_VERSION_LSB        28
`define ID_PART_LSB           12
`define ID_MANUF_LSB          1
`define ID_WIDTH              32

`define DEBUG_CHAIN_LEN       9
`define DEBUG_CLEAR_DIRTY_BIT 0
`define DEBUG_ACCESS_BIT      1

`define CLK_PERIOD_NS         5
`define RESET_TIMEOUT_NS      65000

`endif

// File: rtl/scan_debug_pkg.sv
package scan_debug_pkg;

  typedef enum logic [15:0] {
    TAP_RESET      = 16'h0001,
    TAP_IDLE       = 16'h0002,
    TAP_SEL_DR     = 16'h0004,
    TAP_CAPTURE_DR = 16'h0008,
    TAP_SHIFT_DR   = 16'h0010,
    TAP_EXIT1_DR   = 16'h0020,
    TAP_PAUSE_DR   = 16'h0040,
    TAP_EXIT2_DR   = 16'h0080,
    TAP_UPDATE_DR  = 16'h0100,
    TAP_SEL_IR     = 16'h0200,
    TAP_CAPTURE_IR = 16'h0400,
    TAP_SHIFT_IR   = 16'h0800,
    TAP_EXIT1_IR   = 16'h1000,
    TAP_PAUSE_IR   = 16'h2000,
    TAP_EXIT2_IR   = 16'h4000,
    TAP_UPDATE_IR  = 16'h8000
  } tap_state_type;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } cpu_req_type;

  typedef struct packed {
    logic port_enable;
    logic debug_enable;
    logic lock_one;
    logic lock_two;
  } fuse_type;

endpackage

// File: rtl/scan_debug_channel.sv
`include "scan_debug_defs.svh"

module scan_debug_channel
  import scan_debug_pkg::*;
#(
  parameter int          PINS            = 8,
  parameter logic [3:0]  VERSION         = 4'h0, // arbitrary value
  parameter logic [15:0] PART_NUMBER     = 16'h5a5a, // arbitrary value
  parameter logic [10:0] MANUFACTURER    = 11'h2aa, // arbitrary value
  parameter int          TIMEOUT_CYCLES  = `RESET_TIMEOUT_NS / `CLK_PERIOD_NS
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  output logic                   tdo,
  output logic                   tdo_oe,
  input  wire fuse_type          fuses,
  input  wire logic              ext_reset_n,
  input  wire cpu_req_type       cpu_req,
  output logic [7:0]             cpu_rdata,
  input  wire logic [7:0]        std_io_rdata,
  output logic                   std_io_rd,
  output logic                   std_io_wr,
  output logic [7:0]             std_io_wdata,
  input  wire logic              fuse_prog_req,
  input  wire logic              chip_erase,
  output logic                   fuse_prog_grant,
  output logic                   fuse_prog_refused,
  output logic                   core_reset,
  output logic                   tap_enabled,
  input  wire logic [PINS-1:0]   core_pin_out,
  input  wire logic [PINS-1:0]   core_pin_oe,
  input  wire logic [PINS-1:0]   pin_in,
  output logic [PINS-1:0]        pin_out,
  output logic [PINS-1:0]        pin_oe
);

  localparam int DRW = (3 * PINS > `ID_WIDTH) ? 3 * PINS : `ID_WIDTH;
  localparam logic [31:0] TIMEOUT = 32'(TIMEOUT_CYCLES);

  if (PINS < 1 || TIMEOUT_CYCLES < 1) begin : g_bad_params
    $error("scan_debug_channel: PINS and TIMEOUT_CYCLES must be at least 1");
  end

  // two-stage synchronisers for the scan pins, external reset and pin inputs
  logic [3+PINS:0] sync1_q;
  logic [3+PINS:0] sync2_q;
  logic            tck_last_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q    <= '0;
      sync2_q    <= '0;
      tck_last_q <= 1'b0;
    end else begin
      sync1_q    <= {pin_in, ext_reset_n, tdi, tms, tck};
      sync2_q    <= sync1_q;
      tck_last_q <= sync2_q[0];
    end
  end

  logic            tck_s;
  logic            tms_s;
  logic            tdi_s;
  logic            ext_reset_n_s;
  logic [PINS-1:0] pin_in_s;
  logic            tck_rise;
  logic            tck_fall;
  assign tck_s         = sync2_q[0];
  assign tms_s         = sync2_q[1];
  assign tdi_s         = sync2_q[2];
  assign ext_reset_n_s = sync2_q[3];
  assign pin_in_s      = sync2_q[3+PINS:4];
  assign tck_rise      = tck_s & ~tck_last_q;
  assign tck_fall      = ~tck_s & tck_last_q;

  // core control register, interface disable bit with timed write
  logic [7:0] core_ctrl_q;
  logic [2:0] timed_cnt_q;
  logic       timed_val_q;
  logic       core_ctrl_wr;
  assign core_ctrl_wr = cpu_req.wr && cpu_req.addr == `ADDR_CORE_CONTROL;
  always_ff @(posedge clk) begin
    if (rst) begin
      core_ctrl_q <= `CORE_CONTROL_RESET;
      timed_cnt_q <= 3'h0;
      timed_val_q <= 1'b0;
    end else if (core_ctrl_wr) begin
      if (timed_cnt_q != 3'h0 && timed_val_q == cpu_req.wdata[`INTERFACE_DISABLE_BIT]) begin
        core_ctrl_q[`INTERFACE_DISABLE_BIT] <= timed_val_q;
        timed_cnt_q <= 3'h0;
      end else begin
        timed_cnt_q <= `TIMED_WRITE_WINDOW;
        timed_val_q <= cpu_req.wdata[`INTERFACE_DISABLE_BIT];
      end
    end else if (timed_cnt_q != 3'h0) begin
      timed_cnt_q <= timed_cnt_q - 3'h1;
    end
  end

  logic tap_en;
  assign tap_en = fuses.port_enable & ~core_ctrl_q[`INTERFACE_DISABLE_BIT];

  // tap controller, held in test-logic-reset while disabled
  tap_state_type state_q;
  tap_state_type state_d;
  always_comb begin
    state_d = state_q;
    case (state_q)
      TAP_RESET:      state_d = tms_s ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:       state_d = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR:     state_d = tms_s ? TAP_SEL_IR : TAP_CAPTURE_DR;
      TAP_CAPTURE_DR: state_d = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR:   state_d = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR:   state_d = tms_s ? TAP_UPDATE_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR:   state_d = tms_s ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR:   state_d = tms_s ? TAP_UPDATE_DR : TAP_SHIFT_DR;
      TAP_UPDATE_DR:  state_d = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR:     state_d = tms_s ? TAP_RESET : TAP_CAPTURE_IR;
      TAP_CAPTURE_IR: state_d = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR:   state_d = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR:   state_d = tms_s ? TAP_UPDATE_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR:   state_d = tms_s ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR:   state_d = tms_s ? TAP_UPDATE_IR : TAP_SHIFT_IR;
      TAP_UPDATE_IR:  state_d = tms_s ? TAP_SEL_DR : TAP_IDLE;
      default:        state_d = TAP_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst || !tap_en) begin
      state_q <= TAP_RESET;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  // instruction register
  logic [`IR_WIDTH-1:0] ir_shift_q;
  logic [`IR_WIDTH-1:0] ir_q;
  always_ff @(posedge clk) begin
    if (rst || state_q == TAP_RESET) begin
      ir_shift_q <= `IR_CAPTURE_VALUE;
      ir_q       <= `INSTR_IDCODE;
    end else if (tck_rise) begin
      case (state_q)
        TAP_CAPTURE_IR: ir_shift_q <= `IR_CAPTURE_VALUE;
        TAP_SHIFT_IR:   ir_shift_q <= {tdi_s, ir_shift_q[`IR_WIDTH-1:1]};
        TAP_UPDATE_IR:  ir_q <= ir_shift_q;
        default:        ir_shift_q <= ir_shift_q;
      endcase
    end
  end

  logic sel_extest;
  logic sel_sample;
  logic sel_boundary;
  logic sel_idcode;
  logic sel_debug;
  logic sel_reset_req;
  assign sel_extest    = ir_q == `INSTR_EXTEST;
  assign sel_sample    = ir_q == `INSTR_SAMPLE_PRELOAD;
  assign sel_boundary  = sel_extest | sel_sample;
  assign sel_idcode    = ir_q == `INSTR_IDCODE;
  assign sel_debug     = ir_q >= `INSTR_DEBUG_ACCESS_A
                      && ir_q <= `INSTR_DEBUG_ACCESS_D;
  assign sel_reset_req = ir_q == `INSTR_RESET_REQUEST;

  // shared data register path; unselected codes act as bypass
  logic [DRW-1:0]  dr_q;
  logic [DRW-1:0]  dr_d;
  logic [DRW-1:0]  dr_capture;
  logic [31:0]     id_value;
  logic [7:0]      msg_q;
  logic            dirty_q;
  logic [PINS-1:0] latch_data_q;
  logic [PINS-1:0] latch_ctrl_q;
  int              dr_len;

  assign id_value = {VERSION, PART_NUMBER, MANUFACTURER, 1'b1};

  always_comb begin
    dr_capture = '0;
    dr_len     = 1;
    if (sel_idcode) begin
      dr_capture[`ID_WIDTH-1:0] = id_value;
      dr_len = `ID_WIDTH;
    end else if (sel_boundary) begin
      dr_capture[3*PINS-1:0] = {pin_in_s, pin_oe, pin_out};
      dr_len = 3 * PINS;
    end else if (sel_debug) begin
      dr_capture[`DEBUG_CHAIN_LEN-1:0] = {dirty_q, msg_q};
      dr_len = `DEBUG_CHAIN_LEN;
    end
  end

  always_comb begin
    dr_d = '0;
    for (int i = 0; i < DRW; i++) begin
      if (i == dr_len - 1) begin
        dr_d[i] = tdi_s;
      end else if (i < DRW - 1) begin
        dr_d[i] = dr_q[i+1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dr_q <= '0;
    end else if (tck_rise && state_q == TAP_CAPTURE_DR) begin
      dr_q <= dr_capture;
    end else if (tck_rise && state_q == TAP_SHIFT_DR) begin
      dr_q <= dr_d;
    end
  end

  logic update_dr;
  assign update_dr = tck_rise && state_q == TAP_UPDATE_DR;

  always_ff @(posedge clk) begin
    if (rst) begin
      latch_data_q <= '0;
      latch_ctrl_q <= '0;
    end else if (update_dr && sel_boundary) begin
      latch_data_q <= dr_q[PINS-1:0];
      latch_ctrl_q <= dr_q[2*PINS-1:PINS];
    end
  end

  // reset register: the shift stage itself drives the reset
  logic reset_bit_q;
  always_ff @(posedge clk) begin
    if (rst || state_q == TAP_RESET) begin
      reset_bit_q <= 1'b0;
    end else if (tck_rise && state_q == TAP_SHIFT_DR && sel_reset_req) begin
      reset_bit_q <= tdi_s;
    end
  end

  // debugger side of the message channel
  logic debug_ok;
  logic dbg_access_q;
  logic dbg_clear;
  assign debug_ok  = fuses.debug_enable & ~fuses.lock_one & ~fuses.lock_two;
  assign dbg_clear = update_dr && sel_debug && dr_q[`DEBUG_CLEAR_DIRTY_BIT];
  always_ff @(posedge clk) begin
    if (rst || !debug_ok) begin
      dbg_access_q <= 1'b0;
    end else if (update_dr && sel_debug) begin
      dbg_access_q <= dr_q[`DEBUG_ACCESS_BIT];
    end
  end

  // cpu side of the message channel
  logic chan_sel;
  logic chan_wr;
  logic chan_rd;
  assign chan_sel = cpu_req.addr == `ADDR_DEBUG_MESSAGE
                 && fuses.debug_enable && dbg_access_q;
  assign chan_wr  = cpu_req.wr && chan_sel;
  assign chan_rd  = cpu_req.rd && chan_sel;

  always_ff @(posedge clk) begin
    if (rst) begin
      msg_q <= `DEBUG_MESSAGE_RESET;
    end else if (chan_wr) begin
      msg_q <= cpu_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dirty_q <= 1'b0;
    end else if (chan_wr) begin
      dirty_q <= 1'b1;
    end else if (dbg_clear) begin
      dirty_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_rdata    <= 8'h00;
      std_io_rd    <= 1'b0;
      std_io_wr    <= 1'b0;
      std_io_wdata <= 8'h00;
    end else begin
      std_io_rd    <= cpu_req.rd && cpu_req.addr == `ADDR_DEBUG_MESSAGE && !chan_sel;
      std_io_wr    <= cpu_req.wr && cpu_req.addr == `ADDR_DEBUG_MESSAGE && !chan_sel;
      std_io_wdata <= cpu_req.wdata;
      if (chan_rd) begin
        cpu_rdata <= {dirty_q, msg_q[6:0]};
      end else if (cpu_req.rd && cpu_req.addr == `ADDR_CORE_CONTROL) begin
        cpu_rdata <= core_ctrl_q;
      end else if (cpu_req.rd && cpu_req.addr == `ADDR_DEBUG_MESSAGE) begin
        cpu_rdata <= std_io_rdata;
      end else begin
        cpu_rdata <= 8'h00;
      end
    end
  end

  // debug fuse programming gate
  logic erased_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      erased_q          <= 1'b0;
      fuse_prog_grant   <= 1'b0;
      fuse_prog_refused <= 1'b0;
    end else begin
      if (chip_erase) begin
        erased_q <= 1'b1;
      end
      fuse_prog_grant   <= fuse_prog_req
                        && (!(fuses.lock_one || fuses.lock_two) || erased_q);
      fuse_prog_refused <= fuse_prog_req
                        && (fuses.lock_one || fuses.lock_two) && !erased_q;
    end
  end

  // device reset with time-out after release
  logic        reset_any;
  logic [31:0] timeout_q;
  assign reset_any = ~ext_reset_n_s | reset_bit_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      timeout_q  <= TIMEOUT;
      core_reset <= 1'b1;
    end else begin
      if (reset_any) begin
        timeout_q <= TIMEOUT;
      end else if (timeout_q != 32'h0) begin
        timeout_q <= timeout_q - 32'h1;
      end
      core_reset <= reset_any || timeout_q != 32'h0;
    end
  end

  // pins: external test overrides, reset floats, else core drives
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else if (sel_extest) begin
      pin_out <= latch_data_q;
      pin_oe  <= latch_ctrl_q;
    end else if (reset_any || core_reset) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      pin_out <= core_pin_out;
      pin_oe  <= core_pin_oe;
    end
  end

  // scan output changes on the falling test clock edge
  always_ff @(posedge clk) begin
    if (rst) begin
      tdo         <= 1'b0;
      tdo_oe      <= 1'b0;
      tap_enabled <= 1'b0;
    end else begin
      tap_enabled <= tap_en;
      if (tck_fall) begin
        tdo_oe <= state_q == TAP_SHIFT_DR || state_q == TAP_SHIFT_IR;
        if (state_q == TAP_SHIFT_IR) begin
          tdo <= ir_shift_q[0];
        end else if (sel_reset_req) begin
          tdo <= reset_bit_q;
        end else begin
          tdo <= dr_q[0];
        end
      end
    end
  end

endmodule

// File: dv/scan_debug_channel_props.sv
module scan_debug_channel_props
  import scan_debug_pkg::*;
#(
  parameter int PINS           = 8,
  parameter int TIMEOUT_CYCLES = 8
) (
  input wire logic            clk,
  input wire logic            rst,
  input wire fuse_type        fuses,
  input wire logic            ext_reset_n,
  input wire cpu_req_type     cpu_req,
  input wire logic [7:0]      cpu_rdata,
  input wire logic [7:0]      std_io_rdata,
  input wire logic            std_io_rd,
  input wire logic            std_io_wr,
  input wire logic [7:0]      std_io_wdata,
  input wire logic            fuse_prog_req,
  input wire logic            chip_erase,
  input wire logic            fuse_prog_grant,
  input wire logic            fuse_prog_refused,
  input wire logic            core_reset,
  input wire logic            tdo_oe,
  input wire logic            tap_enabled,
  input wire logic [PINS-1:0] pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic erased_q;
  int   hold_q;
  logic w31;
  logic locked;

  assign w31 = cpu_req.wr && cpu_req.addr == 6'h31;
  assign locked = fuses.lock_one || fuses.lock_two;

  always_ff @(posedge clk) begin
    if (rst) begin
      erased_q <= 1'b0;
    end else if (chip_erase) begin
      erased_q <= 1'b1;
    end
  end

  // cycles since the external reset pin was last low
  always_ff @(posedge clk) begin
    if (rst || !ext_reset_n) begin
      hold_q <= 0;
    end else if (hold_q < 100000) begin
      hold_q <= hold_q + 1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  reset_state_a:
    assert property ($fell(rst) |-> core_reset && !tdo_oe && pin_oe == '0)
    else $error("outputs not in reset state");
  tap_gate_a:
    assert property (!fuses.port_enable |-> ##[1:2] !tap_enabled)
    else $error("port stays enabled without fuse");
  std_route_a:
    assert property (w31 && !fuses.debug_enable |=> std_io_wr
      && std_io_wdata == $past(cpu_req.wdata))
    else $error("write not routed to standard location");
  std_read_a:
    assert property (cpu_req.rd && cpu_req.addr == 6'h31 && !fuses.debug_enable
      |=> std_io_rd && cpu_rdata == $past(std_io_rdata))
    else $error("read not routed to standard location");
  std_only_a:
    assert property (!w31 |=> !std_io_wr)
    else $error("stray standard write");
  dirty_read_a:
    assert property (w31 ##1 cpu_req.rd && cpu_req.addr == 6'h31 && !std_io_wr
      |=> cpu_rdata == {1'b1, $past(cpu_req.wdata[6:0], 2)})
    else $error("read after write lacks dirty flag or byte");
  fuse_refuse_a:
    assert property (fuse_prog_req && locked && !erased_q |=> fuse_prog_refused
      && !fuse_prog_grant)
    else $error("locked fuse request not refused");
  fuse_grant_a:
    assert property (fuse_prog_req && (!locked || erased_q) |=> fuse_prog_grant
      && !fuse_prog_refused)
    else $error("allowed fuse request not granted");
  ext_reset_a:
    assert property (!ext_reset_n |-> ##[1:4] core_reset)
    else $error("external reset not followed");
  timeout_a:
    assert property ($fell(core_reset) |-> hold_q >= TIMEOUT_CYCLES)
    else $error("reset released before time-out");

  cover property (fuse_prog_grant);
  cover property (std_io_wr);
  cover property ($fell(core_reset));
  cover property ($rose(tdo_oe));
endmodule

bind scan_debug_channel scan_debug_channel_props #(
  .PINS(PINS),
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) scan_debug_channel_props_i (.*);

// File: dv/jtag_host_model.sv
module jtag_host_model (
  input  wire logic clk,
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] dout;
  event        done;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // one 160 ns period, tdo taken just before the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    repeat (16) @(negedge clk);
    o = tdo;
    tck = 1'b1;
    repeat (16) @(negedge clk);
    tck = 1'b0;
  endtask

  // idle, select, capture, shift, exit1, update, idle; tck then stands low
  task automatic shift(input logic ir, input int n, input logic [31:0] din);
    logic o;
    @(negedge clk);
    step(1'b0, 1'b0, o);
    step(1'b1, 1'b0, o);
    if (ir) begin
      step(1'b1, 1'b0, o);
    end
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, ~din[n-1], o);
    step(1'b0, ~din[n-1], o);
    -> done;
  endtask
endmodule

// File: dv/scan_debug_channel_tb_top.sv
module scan_debug_channel_tb_top
  import scan_debug_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          PINS = 8;
  localparam int          TMO  = 8;
  localparam logic [3:0]  VER  = 4'h3;     // arbitrary value
  localparam logic [15:0] PART = 16'h1c2d; // arbitrary value
  localparam logic [10:0] MANU = 11'h155;  // arbitrary value
  localparam logic [17:0] M_R  = 18'h20000;
  localparam logic [17:0] M_T  = 18'h10000;
  localparam logic [17:0] M_P  = 18'h0ffff;
  logic            clk, rst, tck, tms, tdi, tdo, tdo_oe, ext_reset_n, rd_pend;
  logic            std_io_rd, std_io_wr, fuse_prog_req, chip_erase;
  logic            fuse_prog_grant, fuse_prog_refused, core_reset, tap_enabled;
  fuse_type        fuses;
  cpu_req_type     cpu_req;
  logic [7:0]      cpu_rdata, std_io_rdata, std_io_wdata, b, d, o, p, i8;
  logic [PINS-1:0] core_pin_out, core_pin_oe, pin_in, pin_out, pin_oe;
  logic [31:0]     exp_q[$], msk_q[$];
  int              n_errors = 0;
  int              check_count = 0;
  event            probe_ev;

  scan_debug_channel #(.PINS(PINS), .VERSION(VER), .PART_NUMBER(PART),
    .MANUFACTURER(MANU), .TIMEOUT_CYCLES(TMO)) scan_debug_channel_i (.*);
  jtag_host_model jtag_host_model_i (.*);

  always #2.5 clk = ~clk;

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] act);
    logic [31:0] e, m;
    e = exp_q.pop_front();
    m = msk_q.pop_front();
    check_count++;
    if ((act & m) !== (e & m)) begin
      n_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e & m, act & m);
    end
  endtask

  always @(posedge clk) rd_pend <= cpu_req.rd;
  always @(negedge clk) if (rd_pend) cmp({24'h0, cpu_rdata});
  always @(jtag_host_model_i.done) cmp(jtag_host_model_i.dout);
  always @(probe_ev) cmp({14'h0, core_reset, tap_enabled, pin_oe, pin_out});

  task automatic cpu(input logic r, input logic [5:0] a, input logic [7:0] wd, e);
    @(negedge clk);
    cpu_req = '{rd: r, wr: !r, addr: a, wdata: wd};
    if (r) begin
      exp_q.push_back({24'h0, e});
      msk_q.push_back(32'hff);
    end
  endtask

  task automatic idle();
    @(negedge clk);
    cpu_req = '0;
  endtask

  task automatic scan(input logic ir, input int n, input logic [31:0] din, e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    jtag_host_model_i.shift(ir, n, din);
  endtask

  task automatic instr(input logic [3:0] c);
    scan(1'b1, 4, {28'h0, c}, 32'h1, 32'hf);
  endtask

  task automatic probe(input logic [17:0] e, m);
    @(negedge clk);
    exp_q.push_back({14'h0, e});
    msk_q.push_back({14'h0, m});
    -> probe_ev;
  endtask

  task automatic fuse_req();
    fuse_prog_req = 1'b1;
    @(negedge clk);
    fuse_prog_req = 1'b0;
    @(negedge clk);
  endtask

  initial begin
    #200000;
    n_errors++;
    conclude();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ext_reset_n = 1'b1;
    fuses = '{1'b1, 1'b0, 1'b0, 1'b0};
    cpu_req = '0;
    std_io_rdata = 8'h5a;
    fuse_prog_req = 1'b0;
    chip_erase = 1'b0;
    core_pin_out = '0;
    core_pin_oe = '1;
    pin_in = '0;
    void'($urandom(32'h2f30));
    repeat (5) @(negedge clk);
    probe(M_R, M_R | M_T | 18'h0ff00);
    rst = 1'b0;
    repeat (TMO - 1) @(negedge clk);
    probe(M_R, M_R);
    repeat (4) @(negedge clk);
    probe(18'h0, M_R);
    scan(1'b0, 32, $urandom, {VER, PART, MANU, 1'b1}, '1);
    instr(4'hf);
    b = $urandom;
    scan(1'b0, 8, {24'h0, b}, {b[6:0], 1'b0}, 32'hff);
    cpu(1'b0, 6'h31, 8'h11, 8'h0);
    cpu(1'b1, 6'h20, 8'h0, 8'h0);
    cpu(1'b1, 6'h31, 8'h0, 8'h5a);
    idle();
    fuses.debug_enable = 1'b1;
    instr(4'h8);
    scan(1'b0, 9, 32'h2, 32'h0, 32'h1ff);
    for (int c = 8; c < 12; c++) begin
      b = $urandom;
      cpu(1'b0, 6'h31, b, 8'h0);
      cpu(1'b1, 6'h31, 8'h0, {1'b1, b[6:0]});
      idle();
      instr(c[3:0]);
      scan(1'b0, 9, 32'h3, {23'h0, 1'b1, b}, 32'h1ff);
      cpu(1'b1, 6'h31, 8'h0, {1'b0, b[6:0]});
      idle();
    end
    cpu(1'b0, 6'h35, 8'h80, 8'h0);
    cpu(1'b0, 6'h35, 8'h80, 8'h0);
    cpu(1'b1, 6'h35, 8'h0, 8'h80);
    idle();
    probe(18'h0, M_T);
    cpu(1'b0, 6'h35, 8'h0, 8'h0);
    cpu(1'b0, 6'h35, 8'h0, 8'h0);
    idle();
    fuses.port_enable = 1'b0;
    probe(18'h0, M_T);
    fuses.port_enable = 1'b1;
    probe(M_T, M_T);
    d = $urandom;
    o = $urandom;
    i8 = $urandom;
    p = $urandom;
    core_pin_out = d;
    core_pin_oe = o;
    pin_in = i8;
    instr(4'h2);
    scan(1'b0, 24, {8'h0, 8'hff, p}, {i8, o, d}, 32'hffffff);
    probe({2'b0, o, d}, M_P);
    instr(4'h0);
    probe({2'b0, 8'hff, p}, M_P);
    instr(4'hc);
    scan(1'b0, 1, 32'h1, 32'h0, 32'h0);
    probe(M_R, M_R | 18'h0ff00);
    scan(1'b0, 1, 32'h0, 32'h0, 32'h0);
    probe(18'h0, M_R);
    ext_reset_n = 1'b0;
    repeat (4) @(negedge clk);
    probe(M_R, M_R);
    ext_reset_n = 1'b1;
    repeat (TMO + 8) @(negedge clk);
    fuses.lock_one = 1'b1;
    fuse_req();
    chip_erase = 1'b1;
    @(negedge clk);
    chip_erase = 1'b0;
    fuse_req();
    repeat (4) @(negedge clk);
    conclude();
  end
endmodule
